// *** design/rlf_pkg.sv ***
// Purpose: shared constants and carriers of the receive fault and status block
// Assumes: one receive clock, all inputs produced by logic on that clock
// Notes:   register offsets are byte addresses of 32-bit words
package rlf_pkg;
    // register map
    localparam logic [7:0]  RLF_OFS_CTRL    = 8'h00;   // control: test pattern enable
    localparam logic [7:0]  RLF_OFS_MAXLEN  = 8'h04;   // maximum packet length
    localparam logic [7:0]  RLF_OFS_STATUS  = 8'h08;   // live status levels
    localparam logic [7:0]  RLF_OFS_MISCNT  = 8'h0C;   // accumulated mismatches
    // field positions
    localparam int          RLF_CTRL_TPEN   = 0;       // test pattern enable bit
    localparam int          RLF_ST_LOCAL    = 0;       // combined local fault
    localparam int          RLF_ST_REMOTE   = 1;       // remote fault
    localparam int          RLF_ST_INT      = 2;       // internal local fault
    localparam int          RLF_ST_RCV      = 3;       // received local fault
    localparam int          RLF_ST_LINK     = 4;       // link up
    localparam int          RLF_LEN_W       = 15;      // max length field width
    localparam int          RLF_CNT_W       = 16;      // mismatch counter width
    // reset values
    localparam logic [14:0] RLF_MAXLEN_RST  = 15'h2580; // default length limit
    localparam logic [31:0] RLF_ZERO_WORD   = 32'h0000_0000;
    // link fault sequencing
    localparam int          RLF_COL_CLEAN   = 128;     // clean columns to clear a fault
    localparam int          RLF_SEQ_NEED    = 4;       // fault sets needed to raise a fault

    // fault states of the link
    typedef enum logic [1:0] {RLF_OK, RLF_LOCAL, RLF_REMOTE} rlf_fault_t;

    // one received pcs block, already decoded
    typedef struct packed {
        logic       valid;       // a block (one column) arrives
        logic       ctrl;        // block is a control block
        logic       code_ok;     // its control code is a valid one
        logic       seq;         // block carries a fault ordered set
        logic       seq_remote;  // fault set is remote (else local)
    } rlf_blk_t;

    // receive packet beat as seen by the mac
    typedef struct packed {
        logic       valid;       // beat present
        logic       sop;         // first beat of a packet
        logic       eop;         // last beat of a packet
        logic [3:0] bytes;       // bytes carried by this beat
    } rlf_pkt_t;

    // causes of an internal local fault plus lock state
    typedef struct packed {
        logic       tp_gen;      // test pattern generation active
        logic       align_lost;  // lane alignment lost
        logic       hi_ber;      // high bit error rate
        logic       blk_lock;    // block lock achieved
    } rlf_cause_t;
endpackage

// *** design/rlf_fault_sm.sv ***
// Purpose: link fault sequencer over received fault ordered sets
// Assumes: blk.valid marks one column per cycle at most
// Notes:   a change of fault type restarts the set count
module rlf_fault_sm #(
    parameter int COL_CLEAN = rlf_pkg::RLF_COL_CLEAN,   // clean columns to clear
    parameter int SEQ_NEED  = rlf_pkg::RLF_SEQ_NEED     // sets to raise a fault
) (
    input  wire logic             clk,          // receive clock
    input  wire logic             rst,          // synchronous reset, high
    input  wire rlf_pkg::rlf_blk_t blk,         // decoded received block
    output logic                  rcv_local,    // local fault from partner
    output logic                  remote        // remote fault from partner
);
    import rlf_pkg::*;

    if (COL_CLEAN < 2 || SEQ_NEED < 2 || COL_CLEAN > 255) begin : g_bad_param
        $error("rlf_fault_sm: unsupported sequencing parameters");
    end

    rlf_fault_t state_q;        // current link fault state
    logic [7:0] col_cnt_q;      // clean columns since the last fault set or interval end
    logic [2:0] seq_cnt_q;      // matching fault sets seen
    logic       last_rem_q;     // type of the last fault set
    logic       same_seq;       // set matches the ongoing run
    logic       col_end;        // clean interval just completed

    localparam logic [7:0] COL_LAST = 8'(COL_CLEAN - 1);
    localparam logic [2:0] SEQ_LAST = 3'(SEQ_NEED - 1);

    assign same_seq = (seq_cnt_q != 3'h0) && (last_rem_q == blk.seq_remote);
    assign col_end  = blk.valid && !blk.seq && (col_cnt_q == COL_LAST);

    // counters for sets and clean columns
    always_ff @(posedge clk) begin
        if (rst) begin
            col_cnt_q  <= 8'h00;
            seq_cnt_q  <= 3'h0;
            last_rem_q <= 1'b0;
        end else if (blk.valid && blk.seq) begin
            col_cnt_q  <= 8'h00;                                   // R12
            last_rem_q <= blk.seq_remote;
            if (!same_seq) begin
                seq_cnt_q <= 3'h1;                                 // new run
            end else if (seq_cnt_q != SEQ_LAST + 3'h1) begin
                seq_cnt_q <= seq_cnt_q + 3'h1;                     // R12
            end
        end else if (col_end) begin
            col_cnt_q <= 8'h00;                                    // R12
            seq_cnt_q <= 3'h0;
        end else if (blk.valid) begin
            col_cnt_q <= col_cnt_q + 8'h01;
        end
    end

    // fault state itself
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= RLF_OK;
        end else if (blk.valid && blk.seq && same_seq && seq_cnt_q >= SEQ_LAST) begin
            state_q <= blk.seq_remote ? RLF_REMOTE : RLF_LOCAL;    // R9
        end else if (col_end) begin
            state_q <= RLF_OK;                                     // R12
        end
    end

    // level outputs by state
    always_comb begin
        rcv_local = 1'b0;
        remote    = 1'b0;
        case (state_q)
            RLF_OK:     ;                          // no fault
            RLF_LOCAL:  rcv_local = 1'b1;          // R9
            RLF_REMOTE: remote    = 1'b1;          // R7
            default:    ;                          // unreachable codes read clean
        endcase
    end

    a_fault_raise: assert property (@(posedge clk) disable iff (rst)   // R9
        (blk.valid && blk.seq && same_seq && seq_cnt_q >= SEQ_LAST)
        |=> (rcv_local != remote))
        else $error("fault not raised after enough fault sets");
    a_fault_clear: assert property (@(posedge clk) disable iff (rst)   // R12
        col_end |=> (!rcv_local && !remote))
        else $error("fault not cleared after clean interval");
    c_rcv_local: cover property (@(posedge clk) disable iff (rst) $rose(rcv_local));
    c_remote:    cover property (@(posedge clk) disable iff (rst) $rose(remote));
endmodule

// *** design/rlf_trunc.sv ***
// Purpose: packet length tracking and truncation pulse
// Assumes: beats of one packet arrive in order, sop before eop
// Notes:   length saturates, one pulse per packet at most
module rlf_trunc #(
    parameter int LEN_W = rlf_pkg::RLF_LEN_W    // width of the length limit
) (
    input  wire logic              clk,         // receive clock
    input  wire logic              rst,         // synchronous reset, high
    input  wire rlf_pkg::rlf_pkt_t pkt,         // packet beat
    input  wire logic [LEN_W-1:0]  max_len,     // length limit
    output logic                   trunc_q      // one-cycle truncation pulse
);
    import rlf_pkg::*;

    if (LEN_W < 4 || LEN_W > 15) begin : g_bad_param
        $error("rlf_trunc: unsupported length width");
    end

    logic [15:0] len_q;     // bytes so far in current packet
    logic [16:0] len_sum;   // base plus this beat
    logic [15:0] len_d;     // saturated new length
    logic        flag_q;    // current packet already truncated
    logic        over;      // new length exceeds the limit

    assign len_sum = {1'b0, (pkt.sop ? 16'h0000 : len_q)} + {13'h0000, pkt.bytes};
    assign len_d   = len_sum[16] ? 16'hFFFF : len_sum[15:0];
    assign over    = pkt.valid && (len_d > {{(16-LEN_W){1'b0}}, max_len});     // R4

    // running length
    always_ff @(posedge clk) begin
        if (rst) begin
            len_q <= 16'h0000;
        end else if (pkt.valid) begin
            len_q <= pkt.eop ? 16'h0000 : len_d;
        end
    end

    // one pulse per packet, a new packet may pulse next cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            trunc_q <= 1'b0;
            flag_q  <= 1'b0;
        end else begin
            trunc_q <= over && (pkt.sop || !flag_q);                             // R5
            if (pkt.valid && pkt.eop) begin
                flag_q <= 1'b0;
            end else if (over) begin
                flag_q <= 1'b1;
            end
        end
    end

    a_trunc_cause: assert property (@(posedge clk) disable iff (rst)      // R4
        trunc_q |-> $past(over))
        else $error("truncation pulse without over-length packet");
    a_trunc_once: assert property (@(posedge clk) disable iff (rst)       // R5
        (flag_q && !(pkt.valid && pkt.sop)) |=> !trunc_q)
        else $error("second truncation pulse in one packet");
    c_trunc_b2b: cover property (@(posedge clk) disable iff (rst) trunc_q ##1 trunc_q);
endmodule

// *** design/rlf_status_top.sv ***
// Purpose: receive status and fault flags with a small register port
// Assumes: all inputs come from logic on clk; master obeys one-cycle strobes
// Notes:   every output is a flip-flop; read data valid one cycle after strobe
//
// Notes on behaviour
// (R1) 2-bit mismatch count, one cycle per value
// (R2) mismatch output zero unless pattern enabled
// (R3) management may accumulate mismatches into counter
// (R4) flag truncation when length exceeds limit
// (R5) truncation pulse one cycle per packet
// (R6) local fault is internal OR received
// (R7) remote fault is a level
// (R8) internal fault while pattern, misalignment, high ber
// (R9) received fault once enough fault sets
// (R10) indicate blocks with valid control codes
// (R11) single-bit link status output
// (R12) count fault sets, clear after clean interval
module rlf_status_top #(
    parameter int LEN_W     = rlf_pkg::RLF_LEN_W,      // length limit width
    parameter int COL_CLEAN = rlf_pkg::RLF_COL_CLEAN,  // clean columns to clear
    parameter int SEQ_NEED  = rlf_pkg::RLF_SEQ_NEED    // fault sets to raise
) (
    input  wire logic                clk,              // receive clock, 100 MHz
    input  wire logic                rst,              // synchronous reset, high
    input  wire logic [7:0]          reg_addr,         // register byte address
    input  wire logic [31:0]         reg_wdata,        // register write data
    input  wire logic                reg_we,           // write strobe
    input  wire logic                reg_re,           // read strobe
    output logic [31:0]              reg_rdata,        // read data, next cycle
    input  wire logic [1:0]          tp_mismatch,      // raw pattern checker count
    input  wire rlf_pkg::rlf_pkt_t   pkt,              // receive packet beat
    input  wire rlf_pkg::rlf_blk_t   blk,              // decoded pcs block
    input  wire rlf_pkg::rlf_cause_t cause,            // internal fault causes
    output logic [1:0]               stat_mismatch,    // mismatch increment
    output logic                     stat_truncated,   // truncation pulse
    output logic                     stat_local_fault, // combined local fault
    output logic                     stat_remote_fault,// remote fault level
    output logic                     stat_int_fault,   // internal local fault
    output logic                     stat_rcv_fault,   // received local fault
    output logic                     stat_valid_ctrl,  // valid control code seen
    output logic                     stat_link_up      // receive link status
);
    import rlf_pkg::*;

    if (LEN_W != RLF_LEN_W) begin : g_bad_param
        $error("rlf_status_top: length field width must match register");
    end

    // control and counter state
    logic                 tp_en_q;      // test pattern enable
    logic [LEN_W-1:0]     max_len_q;    // packet length limit
    logic [RLF_CNT_W-1:0] mis_cnt_q;    // accumulated mismatches
    logic [RLF_CNT_W-1:0] mis_sum;      // counter plus increment
    logic [1:0]           mis_inc;      // gated increment

    // fault helpers
    logic                 int_d;        // internal fault next value
    logic                 sm_local;     // sequencer local fault
    logic                 sm_remote;    // sequencer remote fault
    logic                 trunc_pulse;  // from length tracker
    logic                 link_d;       // link status next value

    // register write decode
    logic                 wr_ctrl;      // write to control
    logic                 wr_maxlen;    // write to length limit
    logic                 wr_miscnt;    // write clears counter

    assign wr_ctrl   = reg_we && (reg_addr == RLF_OFS_CTRL);
    assign wr_maxlen = reg_we && (reg_addr == RLF_OFS_MAXLEN);
    assign wr_miscnt = reg_we && (reg_addr == RLF_OFS_MISCNT);

    // control register: pattern enable
    always_ff @(posedge clk) begin
        if (rst) begin
            tp_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            tp_en_q <= reg_wdata[RLF_CTRL_TPEN];
        end
    end

    // length limit register
    always_ff @(posedge clk) begin
        if (rst) begin
            max_len_q <= RLF_MAXLEN_RST;
        end else if (wr_maxlen) begin
            max_len_q <= reg_wdata[LEN_W-1:0];
        end
    end

    // gated mismatch increment
    assign mis_inc = tp_en_q ? tp_mismatch : 2'h0;                   // R2

    // mismatch increment output, fresh value each cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_mismatch <= 2'h0;
        end else begin
            stat_mismatch <= mis_inc;                                // R1
        end
    end

    // accumulated mismatches, saturating; increment beats a clear
    assign mis_sum = mis_cnt_q + {{(RLF_CNT_W-2){1'b0}}, mis_inc};
    always_ff @(posedge clk) begin
        if (rst) begin
            mis_cnt_q <= '0;
        end else if (wr_miscnt) begin
            mis_cnt_q <= {{(RLF_CNT_W-2){1'b0}}, mis_inc};           // R3
        end else if (mis_sum < mis_cnt_q) begin
            mis_cnt_q <= '1;                                         // saturate
        end else begin
            mis_cnt_q <= mis_sum;                                    // R3
        end
    end

    // length tracking and truncation pulse
    rlf_trunc #(
        .LEN_W   (LEN_W)
    ) u_trunc (
        .clk     (clk),
        .rst     (rst),
        .pkt     (pkt),
        .max_len (max_len_q),
        .trunc_q (trunc_pulse)
    );

    // truncation output
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_truncated <= 1'b0;
        end else begin
            stat_truncated <= trunc_pulse;                           // R5
        end
    end

    // received fault sequencing
    rlf_fault_sm #(
        .COL_CLEAN (COL_CLEAN),
        .SEQ_NEED  (SEQ_NEED)
    ) u_fault_sm (
        .clk       (clk),
        .rst       (rst),
        .blk       (blk),
        .rcv_local (sm_local),
        .remote    (sm_remote)
    );

    // internal fault from its causes
    assign int_d = cause.tp_gen || cause.align_lost || cause.hi_ber;  // R8

    // fault level outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_int_fault    <= 1'b0;
            stat_rcv_fault    <= 1'b0;
            stat_local_fault  <= 1'b0;
            stat_remote_fault <= 1'b0;
        end else begin
            stat_int_fault    <= int_d;                              // R8
            stat_rcv_fault    <= sm_local;                           // R9
            stat_local_fault  <= int_d || sm_local;                  // R6
            stat_remote_fault <= sm_remote;                          // R7
        end
    end

    // valid control code indication
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_valid_ctrl <= 1'b0;
        end else begin
            stat_valid_ctrl <= blk.valid && blk.ctrl && blk.code_ok; // R10
        end
    end

    // link up: locked, aligned, ber normal
    assign link_d = cause.blk_lock && !cause.align_lost && !cause.hi_ber;
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_link_up <= 1'b0;
        end else begin
            stat_link_up <= link_d;                                  // R11
        end
    end

    // read port, data stand one cycle after the strobe only
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= RLF_ZERO_WORD;
        end else if (reg_re) begin
            reg_rdata <= RLF_ZERO_WORD;
            case (reg_addr)
                RLF_OFS_CTRL: begin
                    reg_rdata[RLF_CTRL_TPEN] <= tp_en_q;
                end
                RLF_OFS_MAXLEN: begin
                    reg_rdata[LEN_W-1:0] <= max_len_q;
                end
                RLF_OFS_STATUS: begin
                    reg_rdata[RLF_ST_LOCAL]  <= stat_local_fault;
                    reg_rdata[RLF_ST_REMOTE] <= stat_remote_fault;
                    reg_rdata[RLF_ST_INT]    <= stat_int_fault;
                    reg_rdata[RLF_ST_RCV]    <= stat_rcv_fault;
                    reg_rdata[RLF_ST_LINK]   <= stat_link_up;
                end
                RLF_OFS_MISCNT: begin
                    reg_rdata[RLF_CNT_W-1:0] <= mis_cnt_q;
                end
                default: begin
                    reg_rdata <= RLF_ZERO_WORD;      // unmapped reads zero
                end
            endcase
        end else begin
            reg_rdata <= RLF_ZERO_WORD;              // zero outside read cycle
        end
    end

    // checks on the outputs
    a_mism_gated: assert property (@(posedge clk) disable iff (rst)   // R2
        !tp_en_q |=> (stat_mismatch == 2'h0))
        else $error("mismatch count while pattern disabled");
    a_mism_value: assert property (@(posedge clk) disable iff (rst)   // R1
        tp_en_q |=> (stat_mismatch == $past(tp_mismatch)))
        else $error("mismatch count differs from checker");
    a_local_or: assert property (@(posedge clk) disable iff (rst)     // R6
        stat_local_fault == (stat_int_fault || stat_rcv_fault))
        else $error("local fault is not the or of its parts");
    a_int_cause: assert property (@(posedge clk) disable iff (rst)    // R8
        int_d |=> stat_int_fault ##0 stat_local_fault)
        else $error("internal fault missing while cause present");
    a_int_drop: assert property (@(posedge clk) disable iff (rst)     // R8
        (!int_d && !sm_local) |=> (!stat_int_fault && !stat_local_fault))
        else $error("internal fault held without cause");
    a_remote_lvl: assert property (@(posedge clk) disable iff (rst)   // R7
        stat_remote_fault |-> !stat_rcv_fault)
        else $error("remote and received local fault together");
    a_ctrl_code: assert property (@(posedge clk) disable iff (rst)    // R10
        (blk.valid && blk.ctrl && blk.code_ok) |=> stat_valid_ctrl)
        else $error("valid control code not indicated");
    a_link_state: assert property (@(posedge clk) disable iff (rst)   // R11
        stat_link_up |-> $past(cause.blk_lock && !cause.hi_ber))
        else $error("link up without lock");
    a_trunc_align: assert property (@(posedge clk) disable iff (rst)  // R5
        trunc_pulse |=> stat_truncated)
        else $error("truncation pulse lost");
    c_mism_seen: cover property (@(posedge clk) disable iff (rst) stat_mismatch != 2'h0);
    c_link_rise: cover property (@(posedge clk) disable iff (rst) $rose(stat_link_up));
endmodule

// *** verification/rlf_partner.sv ***
// Purpose: far-end link partner that sends decoded receive columns
// Assumes: mode changes right after a rising clk edge
// Notes:   mode 0 none, 1 idle, 2 local set, 3 remote set, 4 bad code
module rlf_partner (
    input  wire logic        clk,  // receive clock
    input  wire logic        rst,  // synchronous reset, high
    input  wire logic [2:0]  mode, // column kind to send
    output rlf_pkg::rlf_blk_t blk  // decoded column
);
    timeunit 1ns;
    timeprecision 1ps;
    import rlf_pkg::*;
    logic junk_q; // filler that flips every cycle
    // unused fields keep moving so stale values never look meaningful
    always_ff @(posedge clk) begin
        junk_q <= rst ? 1'b0 : ~junk_q;
    end
    // column contents by kind
    always_comb begin
        case (mode)
            3'd0:    blk = '{1'b0, junk_q, ~junk_q, junk_q, ~junk_q}; // no column
            3'd1:    blk = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};           // idle column
            3'd2:    blk = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};           // local fault set
            3'd3:    blk = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};           // remote fault set
            default: blk = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};           // bad control code
        endcase
    end
endmodule

// *** verification/tb.sv ***
// Purpose: self-checking bench of the receive status and fault block
// Assumes: clean interval shortened to 4 columns
// Notes:   cause cases run from a table, the rest are hand-written
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rlf_pkg::*;
    logic        clk, rst, reg_we, reg_re;           // clock, reset, strobes
    logic [7:0]  reg_addr;                           // register address
    logic [31:0] reg_wdata, reg_rdata;               // register data
    logic [1:0]  tp_mismatch, stat_mismatch;         // mismatch in and out
    logic [2:0]  mode;                               // partner column kind
    rlf_pkt_t    pkt;                                // packet beat
    rlf_blk_t    blk;                                // partner column
    rlf_cause_t  cause;                              // internal fault causes
    logic        trunc, lf, rf, intf, rcvf, vctl, lup; // status outputs
    int          n_errors = 0, samples_checked = 0, n_trunc = 0; // counters
    // cause bits, then expected internal fault and link up
    logic [5:0]  rows [6] = '{6'b0000_00, 6'b0001_01, 6'b1001_11,
                              6'b0101_10, 6'b0011_10, 6'b0000_00};
    rlf_status_top #(.COL_CLEAN(4)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .tp_mismatch(tp_mismatch), .pkt(pkt), .blk(blk), .cause(cause),
        .stat_mismatch(stat_mismatch), .stat_truncated(trunc), .stat_local_fault(lf),
        .stat_remote_fault(rf), .stat_int_fault(intf), .stat_rcv_fault(rcvf),
        .stat_valid_ctrl(vctl), .stat_link_up(lup));
    rlf_partner PEER (.clk(clk), .rst(rst), .mode(mode), .blk(blk));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // counts every cycle the truncation flag stands high
    always @(posedge clk) begin
        if (trunc === 1'b1) n_trunc++;
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task chkb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        #1 chk("rdata", e, reg_rdata);
        @(posedge clk);
    endtask
    task beat(input logic s, input logic e, input logic [3:0] b);
        pkt <= '{1'b1, s, e, b};
        @(posedge clk);
    endtask
    task send(input logic [2:0] m, input int n);
        mode <= m;
        repeat (n) @(posedge clk);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog far beyond the 94 cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_of_test;
    end
    initial begin
        {reg_we, reg_re, reg_addr, reg_wdata, tp_mismatch, mode, pkt, cause} = '0;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(RLF_OFS_MAXLEN, 32'h0000_2580);
        rd(RLF_OFS_CTRL, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        $display("test registers done");
        foreach (rows[i]) begin
            cause <= rows[i][5:2];
            @(posedge clk);
            #1 chkb("int", rows[i][1], intf);
            chkb("local", rows[i][1], lf);
            chkb("link", rows[i][0], lup);
            @(posedge clk);
        end
        $display("test causes done");
        tp_mismatch <= 2'h3;
        @(posedge clk);
        #1 chk("mis", 32'h0, {30'h0, stat_mismatch});
        @(posedge clk);
        tp_mismatch <= 2'h0;
        wr(RLF_OFS_CTRL, 32'h0000_0001);
        tp_mismatch <= 2'h2;
        @(posedge clk);
        tp_mismatch <= 2'h3;
        #1 chk("mis", 32'h2, {30'h0, stat_mismatch});
        @(posedge clk);
        tp_mismatch <= 2'h0;
        #1 chk("mis", 32'h3, {30'h0, stat_mismatch});
        @(posedge clk);
        #1 chk("mis", 32'h0, {30'h0, stat_mismatch});
        @(posedge clk);
        rd(RLF_OFS_MISCNT, 32'h0000_0005);
        $display("test mismatch done");
        wr(RLF_OFS_MAXLEN, 32'h0000_000A);
        beat(1'b1, 1'b1, 4'hA);
        beat(1'b1, 1'b0, 4'h8);
        beat(1'b0, 1'b0, 4'h2);
        beat(1'b0, 1'b1, 4'h1);
        beat(1'b1, 1'b1, 4'hB);
        beat(1'b1, 1'b1, 4'hF);
        beat(1'b1, 1'b0, 4'hF);
        beat(1'b0, 1'b1, 4'hF);
        pkt <= '0;
        repeat (3) @(posedge clk);
        chk("trunc", 32'h4, n_trunc);
        $display("test truncation done");
        send(3'd2, 3);
        send(3'd3, 4);
        #1 chkb("remote", 1'b0, rf);
        @(posedge clk);
        #1 chkb("remote", 1'b1, rf);
        chkb("rcv", 1'b0, rcvf);
        @(posedge clk);
        send(3'd1, 4);
        #1 chkb("remote", 1'b1, rf);
        @(posedge clk);
        #1 chkb("remote", 1'b0, rf);
        @(posedge clk);
        send(3'd2, 4);
        @(posedge clk);
        #1 chkb("rcv", 1'b1, rcvf);
        chkb("local", 1'b1, lf);
        @(posedge clk);
        rd(RLF_OFS_STATUS, 32'h0000_0009);
        send(3'd4, 1);
        #1 chkb("vctl", 1'b0, vctl);
        @(posedge clk);
        send(3'd1, 1);
        #1 chkb("vctl", 1'b1, vctl);
        @(posedge clk);
        send(3'd0, 1);
        #1 chkb("vctl", 1'b0, vctl);
        $display("test faults done");
        // a write to the mismatch counter clears it
        @(posedge clk);
        wr(RLF_OFS_MISCNT, 32'h0000_0000);
        rd(RLF_OFS_MISCNT, 32'h0000_0000);
        $display("test counter clear done");
        // mid-run reset with a fault cause standing: internal fault low, length limit and control back to reset values
        cause <= 4'b1000;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chkb("int", 1'b0, intf);
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chkb("int", 1'b1, intf);
        @(posedge clk);
        rd(RLF_OFS_MAXLEN, 32'h0000_2580);
        rd(RLF_OFS_CTRL, 32'h0000_0000);
        $display("test reset done");
        end_of_test;
    end
endmodule
